/* File: inc/wdt_pkg.sv */
// constants, register map and state record of the watchdog timer
// assumes a 100 MHz mclk and a low-frequency tick synchronous to it
package wdt_pkg;
   localparam int          WDT_CLK_HZ      = 100_000_000;
   localparam int          WDT_LF_OSC_HZ   = 31_000;
   localparam int          WDT_BASE_MS     = 1;
   localparam int          WDT_CNT_W       = 24;
   localparam int          WDT_PS_W        = 5;
   localparam int          WDT_IRQ_W       = 2;
   // prescale is (min << code) for legal codes
   localparam logic [23:0] WDT_MIN_PRESCALE = 24'h000020;
   localparam logic [4:0]  WDT_PS_MAX_CODE  = 5'h12;
   localparam logic [4:0]  WDT_PS_RESET     = 5'h0B;
   localparam logic [1:0]  WDT_MODE_ON      = 2'h3;
   localparam logic [1:0]  WDT_MODE_NOSLEEP = 2'h2;
   localparam logic [1:0]  WDT_MODE_SOFT    = 2'h1;
   localparam logic [1:0]  WDT_MODE_OFF     = 2'h0;
   // register byte addresses
   localparam logic [7:0]  WDT_A_CTRL   = 8'h00;
   localparam logic [7:0]  WDT_A_STAT   = 8'h04;
   localparam logic [7:0]  WDT_A_IST    = 8'h08;
   localparam logic [7:0]  WDT_A_IMSK   = 8'h0C;
   localparam logic [7:0]  WDT_A_CNT    = 8'h10;
   // control register fields
   localparam int          WDT_F_SOFTEN = 0;
   localparam int          WDT_F_PS_LO  = 1;
   localparam int          WDT_F_PS_HI  = 5;
   // status register fields
   localparam int          WDT_F_TO     = 0;
   localparam int          WDT_F_PD     = 1;
   localparam int          WDT_F_WATCHDOG_RESET_FLAG   = 2;
   // interrupt bits
   localparam int          WDT_I_AWAKE  = 0;
   localparam int          WDT_I_WAKE   = 1;

   typedef struct packed {
      logic [WDT_PS_W-1:0]  period_select;
      logic                 soft_enable;
      logic [WDT_CNT_W-1:0] cnt;
      logic                 asleep;
      logic                 timeout_flag;
      logic                 powerdown_flag;
      logic                 watchdog_reset_flag;
      logic [WDT_IRQ_W-1:0] ist;
      logic [WDT_IRQ_W-1:0] imsk;
      logic                 rst_req;
      logic                 wake;
      logic                 irq;
      logic                 pready;
      logic                 pslverr;
      logic [31:0]          prdata;
   } wdt_state_t;
endpackage : wdt_pkg

/* File: rtl/wdt_top.sv */
// watchdog timer: lf-tick prescaler/counter, sleep handling, apb registers
// assumes all inputs synchronous to mclk; lf_tick is one mclk pulse per
// low-frequency oscillator cycle; sleep_enter/wake_event come from the cpu
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps

module wdt_top
   import wdt_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        ce,
   input  wire logic [1:0]  watchdog_mode_cfg,
   input  wire logic        lf_tick,
   input  wire logic        clear_watchdog_instr,
   input  wire logic        sleep_enter,
   input  wire logic        wake_event,
   input  wire logic        osc_fail,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             wdt_reset_req,
   output logic             wake_req,
   output logic             timeout_flag,
   output logic             powerdown_flag,
   output logic             watchdog_reset_flag,
   output logic             irq
);

   wdt_state_t           st_r;
   wdt_state_t           st_nxt;
   logic                 active;
   logic                 clr_any;
   logic                 fire;
   logic [WDT_CNT_W-1:0] limit;
   logic                 wr_acc;
   logic                 rd_acc;
   logic                 mapped;

   always_comb begin
      unique case (watchdog_mode_cfg)
         WDT_MODE_ON:      active = 1'b1;
         WDT_MODE_NOSLEEP: active = !st_r.asleep;
         WDT_MODE_SOFT:    active = st_r.soft_enable;
         WDT_MODE_OFF:     active = 1'b0;
      endcase
   end

   always_comb begin
      if (st_r.period_select > WDT_PS_MAX_CODE) begin
         limit = WDT_MIN_PRESCALE;
      end else begin
         limit = WDT_MIN_PRESCALE << st_r.period_select;
      end
   end

   // clear sources; divider selection is deliberately not one
   assign clr_any = clear_watchdog_instr || osc_fail || !active ||
                    (sleep_enter && !st_r.asleep) ||
                    (wake_event && st_r.asleep);

   // timeout on the tick that reaches the count
   assign fire = ce && lf_tick && !clr_any &&
                 (st_r.cnt == limit - 24'h000001);

   assign mapped = (paddr == WDT_A_CTRL) || (paddr == WDT_A_STAT) ||
                   (paddr == WDT_A_IST)  || (paddr == WDT_A_IMSK) ||
                   (paddr == WDT_A_CNT);
   // a write completes on the edge where pready_r is seen high; read data is taken on the edge before, while it is low
   assign wr_acc = psel && penable && st_r.pready && pwrite;
   assign rd_acc = psel && penable && !st_r.pready && !pwrite;

   always_comb begin
      st_nxt         = st_r;
      st_nxt.rst_req = 1'b0;
      st_nxt.wake    = 1'b0;
      st_nxt.pready  = 1'b0;
      st_nxt.pslverr = 1'b0;

      // counter
      if (clr_any) begin
         st_nxt.cnt = '0;
      end else if (fire) begin
         st_nxt.cnt = '0;
      end else if (lf_tick) begin
         st_nxt.cnt = st_r.cnt + 24'h000001;
      end

      // sleep entry clears, counting resumes from zero
      if (sleep_enter && !st_r.asleep) begin
         st_nxt.asleep         = 1'b1;
         st_nxt.powerdown_flag = 1'b0;
         st_nxt.timeout_flag   = 1'b1;
      end else if (wake_event && st_r.asleep) begin
         st_nxt.asleep = 1'b0;
         st_nxt.wake   = 1'b1;
      end

      if (clear_watchdog_instr && !st_r.asleep) begin
         st_nxt.timeout_flag   = 1'b1;
         st_nxt.powerdown_flag = 1'b1;
      end

      // software side of the registers; set below wins over w1c
      if (wr_acc) begin
         unique case (paddr)
            WDT_A_CTRL: begin
               st_nxt.period_select = pwdata[WDT_F_PS_HI:WDT_F_PS_LO];
               st_nxt.soft_enable   = pwdata[WDT_F_SOFTEN];
            end
            WDT_A_STAT: begin
               if (pwdata[WDT_F_WATCHDOG_RESET_FLAG]) begin
                  st_nxt.watchdog_reset_flag = 1'b0;
               end
            end
            WDT_A_IST:  st_nxt.ist  = st_r.ist & ~pwdata[WDT_IRQ_W-1:0];
            WDT_A_IMSK: st_nxt.imsk = pwdata[WDT_IRQ_W-1:0];
            default:    st_nxt.ist  = st_nxt.ist;
         endcase
      end

      if (fire) begin
         st_nxt.timeout_flag = 1'b0;
         if (st_r.asleep) begin
            st_nxt.asleep          = 1'b0;
            st_nxt.wake            = 1'b1;
            st_nxt.ist[WDT_I_WAKE] = 1'b1;
         end else begin
            st_nxt.rst_req             = 1'b1;
            st_nxt.powerdown_flag      = 1'b1;
            st_nxt.watchdog_reset_flag = 1'b1;
            st_nxt.ist[WDT_I_AWAKE]    = 1'b1;
         end
      end

      // apb answer one cycle into the access phase
      if (psel && penable && !st_r.pready) begin
         st_nxt.pready  = 1'b1;
         st_nxt.pslverr = !mapped;
         st_nxt.prdata  = '0;
         if (rd_acc) begin
            unique case (paddr)
               WDT_A_CTRL: begin
                  st_nxt.prdata[WDT_F_PS_HI:WDT_F_PS_LO] = st_r.period_select;
                  st_nxt.prdata[WDT_F_SOFTEN]            = st_r.soft_enable;
               end
               WDT_A_STAT: begin
                  st_nxt.prdata[WDT_F_TO]   = st_r.timeout_flag;
                  st_nxt.prdata[WDT_F_PD]   = st_r.powerdown_flag;
                  st_nxt.prdata[WDT_F_WATCHDOG_RESET_FLAG] = st_r.watchdog_reset_flag;
               end
               WDT_A_IST:  st_nxt.prdata[WDT_IRQ_W-1:0] = st_r.ist;
               WDT_A_IMSK: st_nxt.prdata[WDT_IRQ_W-1:0] = st_r.imsk;
               WDT_A_CNT:  st_nxt.prdata[WDT_CNT_W-1:0] = st_r.cnt;
               default:    st_nxt.prdata = '0;
            endcase
         end
      end

      st_nxt.irq = |(st_nxt.ist & st_nxt.imsk);
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_r                     <= '0;
         st_r.period_select       <= WDT_PS_RESET;
         st_r.soft_enable         <= 1'b0;
         st_r.timeout_flag        <= 1'b1;
         st_r.powerdown_flag      <= 1'b1;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   assign prdata              = st_r.prdata;
   assign pready              = st_r.pready;
   assign pslverr             = st_r.pslverr;
   assign wdt_reset_req       = st_r.rst_req;
   assign wake_req            = st_r.wake;
   assign timeout_flag        = st_r.timeout_flag;
   assign powerdown_flag      = st_r.powerdown_flag;
   assign watchdog_reset_flag = st_r.watchdog_reset_flag;
   assign irq                 = st_r.irq;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence seq_fire_awake;
      fire && !st_r.asleep;
   endsequence
   sequence seq_fire_asleep;
      fire && st_r.asleep;
   endsequence
   sequence seq_reset_out;
      wdt_reset_req && !timeout_flag && watchdog_reset_flag;
   endsequence

   AST_TIMEOUT_RESET: assert property (
      seq_fire_awake |=> seq_reset_out ##1 !wdt_reset_req)
      else $error("awake timeout did not pulse reset");

   AST_SLEEP_WAKE: assert property (
      seq_fire_asleep |=> wake_req && !wdt_reset_req && !st_r.asleep)
      else $error("sleep timeout did not wake");

   AST_NO_TICK: assert property (
      ce && !lf_tick && !clr_any |=> st_r.cnt == $past(st_r.cnt))
      else $error("count moved without lf tick");

   AST_MODE_OFF: assert property (
      ce && watchdog_mode_cfg == WDT_MODE_OFF |=>
      st_r.cnt == '0 && !wdt_reset_req)
      else $error("mode off counted");

   AST_MODE_SLEEP: assert property (
      ce && watchdog_mode_cfg == WDT_MODE_NOSLEEP && st_r.asleep |=>
      st_r.cnt == '0)
      else $error("mode 10 counted in sleep");

   AST_MODE_SOFT: assert property (
      ce && watchdog_mode_cfg == WDT_MODE_SOFT && !st_r.soft_enable |=>
      st_r.cnt == '0)
      else $error("soft mode counted while off");

   AST_MODE_ON: assert property (
      ce && watchdog_mode_cfg == WDT_MODE_ON && lf_tick && !clr_any &&
      !fire |=> st_r.cnt == $past(st_r.cnt) + 24'h000001)
      else $error("always-on mode not counting");

   AST_RESERVED: assert property (
      st_r.period_select > WDT_PS_MAX_CODE |-> limit == WDT_MIN_PRESCALE)
      else $error("reserved code prescale wrong");

   AST_CLEAR: assert property (
      ce && clear_watchdog_instr |=> st_r.cnt == '0 [*1] ##0 !wdt_reset_req)
      else $error("clear instr did not clear");

   AST_OSC_FAIL: assert property (
      ce && osc_fail |=> st_r.cnt == '0 && !wdt_reset_req)
      else $error("oscillator failure did not clear");

   AST_SLEEP_FLAGS: assert property (
      ce && sleep_enter && !st_r.asleep && !fire |=>
      timeout_flag && !powerdown_flag && st_r.cnt == '0)
      else $error("sleep entry flags wrong");

   // counting on from zero while asleep in the always-on mode
   AST_SLEEP_COUNT: assert property (
      ce && watchdog_mode_cfg == WDT_MODE_ON && st_r.asleep && lf_tick &&
      !clr_any && !fire |=> st_r.cnt == $past(st_r.cnt) + 24'h000001)
      else $error("count stalled in sleep");

   AST_WAKE_CLR: assert property (
      ce && wake_event && st_r.asleep |=> st_r.cnt == '0 && wake_req)
      else $error("wake did not clear count");

   AST_SLEEP_STATUS: assert property (
      seq_fire_asleep |=> !timeout_flag && !powerdown_flag)
      else $error("sleep timeout status wrong");

   AST_AWAKE_STATUS: assert property (
      seq_fire_awake |=> powerdown_flag && !timeout_flag)
      else $error("awake timeout status wrong");

   AST_DISABLED: assert property (
      ce && !active |=> st_r.cnt == '0 && !wdt_reset_req)
      else $error("disabled watchdog counted");

   AST_RESET_VAL: assert property (
      disable iff (1'b0) sys_rst |=>
      st_r.period_select == WDT_PS_RESET && !st_r.soft_enable)
      else $error("reset values wrong");

   // one hot at bit 5 plus code, worked out apart from the shifter
   AST_LIMIT: assert property (
      st_r.period_select <= WDT_PS_MAX_CODE |-> $onehot(limit) &&
      limit[st_r.period_select + $clog2(WDT_MIN_PRESCALE)])
      else $error("prescale mapping wrong");

endmodule : wdt_top

/* File: testbench/wdt_top_tb_top.sv */
// self-checking bench for the watchdog timer: apb tasks and call sequences
// assumes ce high except in one freeze test; lf_tick pulsed every mclk so
// prescale counts stay short
`timescale 1ns/1ps
module wdt_top_tb_top;
   import wdt_pkg::*;
   logic        mclk = 0, sys_rst = 1, lf_tick = 0, ce = 1;
   logic        clear_watchdog_instr = 0, sleep_enter = 0;
   logic        wake_event = 0, osc_fail = 0;
   logic [1:0]  watchdog_mode_cfg = WDT_MODE_ON;
   logic        psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, wdt_reset_req, wake_req, irq;
   logic        timeout_flag, powerdown_flag, watchdog_reset_flag;
   int          n_fail = 0, total_checks = 0, n_rst = 0, n_wake = 0, cyc = 0;
   logic        err;

   wdt_top u_dut (.mclk, .sys_rst, .ce, .watchdog_mode_cfg, .lf_tick,
      .clear_watchdog_instr, .sleep_enter, .wake_event, .osc_fail, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .wdt_reset_req, .wake_req, .timeout_flag, .powerdown_flag,
      .watchdog_reset_flag, .irq);

   always #5 mclk = ~mclk;

   task results;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results

   // pulses are counted here; a hang is cut short by the cycle ceiling
   always @(posedge mclk) begin
      if (wdt_reset_req === 1'b1) n_rst++;
      if (wake_req === 1'b1) n_wake++;
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end

   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // one apb transfer: setup, then access held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] d;
      apb(1'b1, a, wd, d);
   endtask : wr

   task tick(input int n);
      lf_tick <= 1'b1;
      repeat (n) @(posedge mclk);
      lf_tick <= 1'b0;
      @(posedge mclk);
   endtask : tick

   // 0 clear instr, 1 osc fail, 2 sleep entry, 3 wake source
   task pulse(input int k);
      clear_watchdog_instr <= (k == 0);
      osc_fail             <= (k == 1);
      sleep_enter          <= (k == 2);
      wake_event           <= (k == 3);
      @(posedge mclk);
      {clear_watchdog_instr, osc_fail, sleep_enter, wake_event} <= 4'h0;
      @(posedge mclk);
   endtask : pulse

   initial begin
      logic [31:0] d;
      logic [4:0]  codes [5];
      logic [1:0]  md [6];
      int          lim, n0, w0;
      int          ex [6];
      codes = '{5'h00, 5'h01, 5'h05, 5'h13, 5'h1F};
      md    = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
      ex    = '{0, 0, 0, 5, 5, 5};
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      apb(1'b0, WDT_A_CTRL, 32'h0, d);
      chk("ctrl reset", d, {26'h0, WDT_PS_RESET, 1'b0});
      apb(1'b0, WDT_A_STAT, 32'h0, d);
      chk("stat reset", d, 32'h3);
      apb(1'b0, 8'h14, 32'h0, d);
      chk("unmapped err", {31'h0, err}, 32'h1);
      foreach (codes[i]) begin
         lim = (codes[i] > WDT_PS_MAX_CODE) ? 32 : 32 << codes[i];
         wr(WDT_A_CTRL, {26'h0, codes[i], 1'b0});
         pulse(0);
         n0 = n_rst;
         tick(lim - 1);
         apb(1'b0, WDT_A_CNT, 32'h0, d);
         chk("count", d, 32'(lim - 1));
         chk("early reset", 32'(n_rst), 32'(n0));
         tick(1);
         repeat (2) @(posedge mclk);
         chk("reset pulse", 32'(n_rst), 32'(n0 + 1));
      end
      apb(1'b0, WDT_A_STAT, 32'h0, d);
      chk("stat timeout", d, 32'h6);
      chk("watchdog_reset_flag pin", {31'h0, watchdog_reset_flag}, 32'h1);
      wr(WDT_A_STAT, 32'h4);
      chk("watchdog_reset_flag clear", {31'h0, watchdog_reset_flag}, 32'h0);
      apb(1'b0, WDT_A_IST, 32'h0, d);
      chk("ist awake", d, 32'h1);
      wr(WDT_A_IMSK, 32'h1);
      repeat (2) @(posedge mclk);
      chk("irq on", {31'h0, irq}, 32'h1);
      wr(WDT_A_IST, 32'h1);
      repeat (2) @(posedge mclk);
      chk("irq off", {31'h0, irq}, 32'h0);
      for (int k = 0; k < 2; k++) begin
         tick(20);
         pulse(k);
         apb(1'b0, WDT_A_CNT, 32'h0, d);
         chk("cleared", d, 32'h0);
      end
      // mode and soft enable table, period code 0
      foreach (md[i]) begin
         pulse(0);
         wr(WDT_A_CTRL, {31'h0, 1'(i == 1 || i == 3)});
         watchdog_mode_cfg <= md[i];
         tick(5);
         apb(1'b0, WDT_A_CNT, 32'h0, d);
         chk("mode count", d, 32'(ex[i]));
      end
      tick(10);
      pulse(2);
      chk("sleep flags", {30'h0, powerdown_flag, timeout_flag}, 32'h1);
      apb(1'b0, WDT_A_CNT, 32'h0, d);
      chk("sleep clear", d, 32'h0);
      tick(10);
      pulse(3);
      apb(1'b0, WDT_A_CNT, 32'h0, d);
      chk("wake clear", d, 32'h0);
      pulse(2);
      n0 = n_rst;
      w0 = n_wake;
      tick(32);
      repeat (2) @(posedge mclk);
      chk("sleep wake", 32'(n_wake), 32'(w0 + 1));
      chk("no reset", 32'(n_rst), 32'(n0));
      apb(1'b0, WDT_A_IST, 32'h0, d);
      chk("ist sleep", d, 32'h2);
      watchdog_mode_cfg <= WDT_MODE_NOSLEEP;
      pulse(2);
      w0 = n_wake;
      tick(40);
      apb(1'b0, WDT_A_CNT, 32'h0, d);
      chk("nosleep cnt", d, 32'h0);
      pulse(3);
      @(posedge mclk);
      chk("event wake", 32'(n_wake), 32'(w0 + 1));
      tick(3);
      apb(1'b0, WDT_A_CNT, 32'h0, d);
      chk("awake again", d, 32'h3);
      ce <= 1'b0;
      tick(4);
      ce <= 1'b1;
      apb(1'b0, WDT_A_CNT, 32'h0, d);
      chk("ce freeze", d, 32'h3);
      results();
   end
endmodule : wdt_top_tb_top
